// File: logic/swa_defs.svh
// Timing, identity and command constants of the single-wire authenticator slave
`ifndef SWA_DEFS_SVH
`define SWA_DEFS_SVH

`define SWA_CLK_MHZ         100
// Times in microseconds
`define SWA_RSTL_STD_US     480
`define SWA_RSTL_OD_US      48
`define SWA_PDH_STD_US      15
`define SWA_PDH_OD_US       2
`define SWA_PDL_STD_US      60
`define SWA_PDL_OD_US       8
`define SWA_RD_HOLD_STD_US  15
`define SWA_RD_HOLD_OD_US   2
`define SWA_WR_SAMP_STD_US  30
`define SWA_WR_SAMP_OD_US   3
// Cycle counts at the 100 MHz clock
`define SWA_RSTL_STD_CYC    (`SWA_RSTL_STD_US * `SWA_CLK_MHZ)
`define SWA_PDL_STD_CYC     (`SWA_PDL_STD_US * `SWA_CLK_MHZ)
`define SWA_RSTL_OD_CYC     (`SWA_RSTL_OD_US * `SWA_CLK_MHZ)
`define SWA_PDH_STD_CYC     (`SWA_PDH_STD_US * `SWA_CLK_MHZ)
`define SWA_PDH_OD_CYC      (`SWA_PDH_OD_US * `SWA_CLK_MHZ)
`define SWA_PDL_OD_CYC      (`SWA_PDL_OD_US * `SWA_CLK_MHZ)
`define SWA_RD_HOLD_STD_CYC (`SWA_RD_HOLD_STD_US * `SWA_CLK_MHZ)
`define SWA_RD_HOLD_OD_CYC  (`SWA_RD_HOLD_OD_US * `SWA_CLK_MHZ)
`define SWA_WR_SAMP_STD_CYC (`SWA_WR_SAMP_STD_US * `SWA_CLK_MHZ)
`define SWA_WR_SAMP_OD_CYC  (`SWA_WR_SAMP_OD_US * `SWA_CLK_MHZ)

// Identity word layout
`define SWA_ID_BITS         64
`define SWA_ID_BODY_BITS    56
`define SWA_CRC_POLY        8'h8c
// Arbitrary identity values
`define SWA_FAMILY_CODE     8'h5a
`define SWA_SERIAL_NUM      48'h0123_4567_89ab

// Network commands
`define SWA_NC_READ_ID      8'h33
`define SWA_NC_MATCH        8'h55
`define SWA_NC_SEARCH       8'hf0
`define SWA_NC_SKIP         8'hcc
`define SWA_NC_RESUME       8'ha5
`define SWA_NC_OD_SKIP      8'h3c
`define SWA_NC_OD_MATCH     8'h69
// Function commands and write status bytes, arbitrary codes
`define SWA_FC_RD_MEM       8'h11
`define SWA_FC_WR_MEM       8'h22
`define SWA_FC_F3           8'h33
`define SWA_FC_F4           8'h44
`define SWA_FC_F5           8'h66
`define SWA_FC_F6           8'h77
`define SWA_WR_PASS         8'haa
`define SWA_WR_FAIL         8'h55

// User memory
`define SWA_MEM_BYTES       24
`define SWA_MEM_BLOCKS      6

`endif

// File: logic/swa_pkg.sv
// Types shared by the authenticator slave and its user memory
package swa_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PRES, ST_ROM, ST_RD_ID, ST_MATCH, ST_SEARCH, ST_FUNC,
    ST_ADDR, ST_RD_MEM, ST_WR_DATA, ST_WR_ACK, ST_DONE
  } swa_state_t;

  typedef struct packed {
    logic [2:0]  sync;
    logic        line;
    logic        od;
    logic        rc;
    swa_state_t  st;
    logic [63:0] sh;
    logic [6:0]  bcnt;
    logic [1:0]  ph;
    logic        miss;
    logic        slot_act;
    logic [15:0] slot_cnt;
    logic [15:0] low_cnt;
    logic [15:0] pcnt;
    logic [15:0] addr;
    logic [7:0]  fcode;
    logic        fvalid;
    logic [7:0]  lfsr;
    logic [7:0]  id_crc;
    logic [6:0]  ccnt;
    logic        id_ok;
    logic        io_oe;
    logic        wr_en;
    logic [7:0]  stat;
  } swa_core_t;

  typedef struct packed {
    logic [23:0][7:0] mem;
    logic [5:0]       prot;
    logic [7:0]       rd_data;
  } swa_mem_st_t;

endpackage

// File: logic/swa_mem.sv
// One-time-programmable user memory with per-block write protection
`timescale 1ns/1ps
`include "swa_defs.svh"

module swa_mem (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [15:0] rd_addr,
  output logic      [7:0]  rd_data,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_blk,
  input  wire logic [31:0] wr_data,
  output logic      [5:0]  prot
);
  import swa_pkg::*;

  swa_mem_st_t r_reg;
  swa_mem_st_t r_next;

  always_comb begin
    r_next = r_reg;
    // Outside user memory reads as blank
    if (rd_addr < 16'(`SWA_MEM_BYTES)) begin
      r_next.rd_data = r_reg.mem[rd_addr[4:0]];
    end else begin
      r_next.rd_data = 8'h00;
    end
    // Whole block written once, then locked; locked blocks stay untouched
    if (wr_en && wr_blk < 3'(`SWA_MEM_BLOCKS) && !r_reg.prot[wr_blk]) begin
      for (int i = 0; i < 4; i++) begin
        r_next.mem[{wr_blk, 2'(i)}] = wr_data[8*i +: 8];
      end
      r_next.prot[wr_blk] = 1'b1;
    end
  end

  // Blank state of unprogrammed cells is all zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rd_data = r_reg.rd_data;
  assign prot    = r_reg.prot;

endmodule

// File: logic/swa_slave.sv
// Single-wire identity, CRC and OTP memory slave
// Notes on behaviour
// - Identity word is family code, 48-bit serial, then CRC byte on top.
// - CRC comes from an 8-bit shift register, polynomial x^8+x^5+x^4+1.
// - CRC register starts at zero, shifts family code then serial, LSB first.
// - Shifting the stored CRC through the register afterwards leaves all zeros.
// - Every serial byte or word moves least significant bit first.
// - Overdrive skip or match switches the device to overdrive timing.
// - After addressing, exactly one of six function commands is decoded.
// - User memory spans addresses 0000h to 0017h.
// - Unprogrammed user memory reads 00h.
// - Programming writes a whole 4-byte block, bits free to 1 or 0.
// - A programmed block is locked against every later programming.
// - Presence low covers min presence delay to delay plus min low time.
// - A low pulse of 480 us or more clears overdrive.
// - Resume flag set by match, search, overdrive match; cleared only when a match or search fails.
`timescale 1ns/1ps
`include "swa_defs.svh"

module swa_slave #(
  parameter logic [15:0] RSTL_STD_CYC = 16'(`SWA_RSTL_STD_CYC),
  parameter logic [15:0] PDL_STD_CYC  = 16'(`SWA_PDL_STD_CYC)
) (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       io_in,
  output logic            io_out,
  output logic            io_oe,
  output logic            overdrive_flag,
  output logic            resume_flag,
  output logic            id_valid,
  output logic [7:0]      func_code,
  output logic            func_valid
);
  import swa_pkg::*;

  localparam logic [15:0] RSTL_OD   = 16'(`SWA_RSTL_OD_CYC);
  localparam logic [15:0] PDH_STD   = 16'(`SWA_PDH_STD_CYC);
  localparam logic [15:0] PDH_OD    = 16'(`SWA_PDH_OD_CYC);
  localparam logic [15:0] PDL_OD    = 16'(`SWA_PDL_OD_CYC);
  localparam logic [15:0] HOLD_STD  = 16'(`SWA_RD_HOLD_STD_CYC);
  localparam logic [15:0] HOLD_OD   = 16'(`SWA_RD_HOLD_OD_CYC);
  localparam logic [15:0] SAMP_STD  = 16'(`SWA_WR_SAMP_STD_CYC);
  localparam logic [15:0] SAMP_OD   = 16'(`SWA_WR_SAMP_OD_CYC);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // User memory
  // ----------------------------------------------------------------
  swa_core_t   r_reg;
  swa_core_t   r_next;
  logic [7:0]  mem_rd;
  logic [5:0]  mem_prot;

  swa_mem u_mem (
    .clock   (clock),
    .rst_n   (rst_n),
    .rd_addr (r_reg.addr),
    .rd_data (mem_rd),
    .wr_en   (r_reg.wr_en),
    .wr_blk  (r_reg.addr[4:2]),
    .wr_data (r_reg.sh[63:32]),
    .prot    (mem_prot)
  );

  // ----------------------------------------------------------------
  // Core state machine
  // ----------------------------------------------------------------
  logic [63:0] id_word;
  logic [15:0] t_samp;
  logic [15:0] t_hold;
  logic [15:0] t_pdh;
  logic [15:0] t_pdl;
  logic        fall;
  logic        rise;
  logic        is_tx;
  logic        txb;
  logic        done;
  logic        rxb;
  logic        crc_in;
  logic        crc_fb;
  logic [7:0]  byte_rx;
  logic        id_bit;
  logic        blk_ok;

  assign id_word = {r_reg.id_crc, `SWA_SERIAL_NUM, `SWA_FAMILY_CODE};

  always_comb begin
    r_next   = r_reg;
    r_next.wr_en = 1'b0;
    t_samp   = r_reg.od ? SAMP_OD : SAMP_STD;
    t_hold   = r_reg.od ? HOLD_OD : HOLD_STD;
    t_pdh    = r_reg.od ? PDH_OD : PDH_STD;
    t_pdl    = r_reg.od ? PDL_OD : PDL_STD_CYC;
    done     = 1'b0;
    rxb      = r_reg.line;
    byte_rx  = {r_reg.line, r_reg.sh[63:57]};
    id_bit   = id_word[r_reg.bcnt[5:0]];
    blk_ok   = 1'b0;
    crc_in   = 1'b0;
    crc_fb   = 1'b0;

    // Line sampling: a change counts once the last two stages agree
    r_next.sync = {r_reg.sync[1:0], io_in};
    if (r_reg.sync[2] == r_reg.sync[1]) begin
      r_next.line = r_reg.sync[2];
    end
    fall = r_reg.line && !r_next.line;
    rise = !r_reg.line && r_next.line;

    // Identity CRC built serially after reset, then self-checked
    if (r_reg.ccnt < 7'(`SWA_ID_BITS)) begin
      crc_in = (r_reg.ccnt < 7'(`SWA_ID_BODY_BITS)) ? id_word[r_reg.ccnt[5:0]]
                                                 : r_reg.id_crc[r_reg.ccnt[2:0]];
      crc_fb = r_reg.lfsr[0] ^ crc_in;
      r_next.lfsr = (r_reg.lfsr >> 1) ^ (crc_fb ? `SWA_CRC_POLY : 8'h00);
      r_next.ccnt = r_reg.ccnt + 7'd1;
      if (r_reg.ccnt == 7'(`SWA_ID_BODY_BITS - 1)) begin
        r_next.id_crc = r_next.lfsr;
      end
    end else begin
      r_next.id_ok = (r_reg.lfsr == 8'h00);
    end

    // Low pulse length, saturating
    if (!r_next.line) begin
      r_next.low_cnt = (r_reg.low_cnt == 16'hffff) ? r_reg.low_cnt : r_reg.low_cnt + 16'd1;
    end else begin
      r_next.low_cnt = 16'd0;
    end

    // Bit direction and value of the current slot, LSB first
    is_tx = 1'b0;
    txb   = 1'b1;
    case (r_reg.st)
      ST_RD_ID: begin
        is_tx = 1'b1;
        txb   = id_bit;
      end
      ST_SEARCH: begin
        is_tx = (r_reg.ph != 2'd2);
        txb   = (r_reg.ph == 2'd0) ? id_bit : !id_bit;
      end
      ST_RD_MEM: begin
        is_tx = 1'b1;
        txb   = mem_rd[r_reg.bcnt[2:0]];
      end
      ST_WR_ACK: begin
        is_tx = 1'b1;
        txb   = r_reg.stat[r_reg.bcnt[2:0]];
      end
      default: begin
        is_tx = 1'b0;
        txb   = 1'b1;
      end
    endcase

    // Slot timing from the master's falling edge
    if (r_reg.st != ST_IDLE && r_reg.st != ST_PRES && r_reg.st != ST_DONE) begin
      if (fall && !r_reg.slot_act) begin
        r_next.slot_act = 1'b1;
        r_next.slot_cnt = 16'd0;
        r_next.io_oe    = is_tx && !txb;
      end else if (r_reg.slot_act) begin
        r_next.slot_cnt = r_reg.slot_cnt + 16'd1;
        if (is_tx && r_reg.slot_cnt == t_hold) begin
          r_next.io_oe    = 1'b0;
          r_next.slot_act = 1'b0;
          done            = 1'b1;
        end else if (!is_tx && r_reg.slot_cnt == t_samp) begin
          r_next.slot_act = 1'b0;
          done            = 1'b1;
        end
      end
    end

    if (done) begin
      r_next.sh   = {rxb, r_reg.sh[63:1]};
      r_next.bcnt = r_reg.bcnt + 7'd1;
      case (r_reg.st)
        ST_ROM: begin
          if (r_reg.bcnt == 7'd7) begin
            r_next.bcnt = 7'd0;
            r_next.miss = 1'b0;
            r_next.ph   = 2'd0;
            case (byte_rx)
              `SWA_NC_READ_ID:  r_next.st = ST_RD_ID;
              `SWA_NC_MATCH:    r_next.st = ST_MATCH;
              `SWA_NC_SEARCH:   r_next.st = ST_SEARCH;
              `SWA_NC_SKIP:     r_next.st = ST_FUNC;
              `SWA_NC_RESUME:   r_next.st = r_reg.rc ? ST_FUNC : ST_IDLE;
              `SWA_NC_OD_SKIP: begin
                r_next.od = 1'b1;
                r_next.st = ST_FUNC;
              end
              `SWA_NC_OD_MATCH: begin
                r_next.od = 1'b1;
                r_next.st = ST_MATCH;
              end
              default:          r_next.st = ST_IDLE;
            endcase
          end
        end
        ST_RD_ID: begin
          if (r_reg.bcnt == 7'd63) begin
            r_next.bcnt = 7'd0;
            r_next.st   = ST_FUNC;
          end
        end
        ST_MATCH: begin
          if (rxb != id_bit) begin
            r_next.miss = 1'b1;
          end
          if (r_reg.bcnt == 7'd63) begin
            r_next.bcnt = 7'd0;
            if (r_next.miss) begin
              r_next.rc = 1'b0;
              r_next.st = ST_IDLE;
            end else begin
              r_next.rc = 1'b1;
              r_next.st = ST_FUNC;
            end
          end
        end
        ST_SEARCH: begin
          r_next.bcnt = r_reg.bcnt;
          r_next.ph   = r_reg.ph + 2'd1;
          if (r_reg.ph == 2'd2) begin
            r_next.ph = 2'd0;
            if (rxb != id_bit) begin
              r_next.rc = 1'b0;
              r_next.st = ST_IDLE;
            end else if (r_reg.bcnt == 7'd63) begin
              r_next.bcnt = 7'd0;
              r_next.rc   = 1'b1;
              r_next.st   = ST_FUNC;
            end else begin
              r_next.bcnt = r_reg.bcnt + 7'd1;
            end
          end
        end
        ST_FUNC: begin
          if (r_reg.bcnt == 7'd7) begin
            r_next.bcnt  = 7'd0;
            r_next.fcode = byte_rx;
            r_next.st    = ST_DONE;
            case (byte_rx)
              `SWA_FC_RD_MEM, `SWA_FC_WR_MEM: begin
                r_next.fvalid = 1'b1;
                r_next.st     = ST_ADDR;
              end
              `SWA_FC_F3, `SWA_FC_F4, `SWA_FC_F5, `SWA_FC_F6: r_next.fvalid = 1'b1;
              default: r_next.fvalid = 1'b0;
            endcase
          end
        end
        ST_ADDR: begin
          r_next.addr = {rxb, r_reg.addr[15:1]};
          if (r_reg.bcnt == 7'd15) begin
            r_next.bcnt = 7'd0;
            r_next.st   = (r_reg.fcode == `SWA_FC_RD_MEM) ? ST_RD_MEM : ST_WR_DATA;
          end
        end
        ST_RD_MEM: begin
          if (r_reg.bcnt == 7'd7) begin
            r_next.bcnt = 7'd0;
            r_next.addr = r_reg.addr + 16'd1;
          end
        end
        ST_WR_DATA: begin
          if (r_reg.bcnt == 7'd31) begin
            blk_ok = (r_reg.addr < 16'(`SWA_MEM_BYTES)) && !mem_prot[r_reg.addr[4:2]];
            r_next.bcnt  = 7'd0;
            r_next.wr_en = blk_ok;
            r_next.stat  = blk_ok ? `SWA_WR_PASS : `SWA_WR_FAIL;
            r_next.st    = ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          if (r_reg.bcnt == 7'd7) begin
            r_next.bcnt = 7'd0;
            r_next.st   = ST_DONE;
          end
        end
        default: r_next.bcnt = r_reg.bcnt;
      endcase
    end

    // Presence pulse after a reset pulse
    if (r_reg.st == ST_PRES) begin
      r_next.pcnt = r_reg.pcnt + 16'd1;
      if (r_reg.pcnt == t_pdh) begin
        r_next.io_oe = 1'b1;
      end else if (r_reg.pcnt == t_pdh + t_pdl) begin
        r_next.io_oe = 1'b0;
        r_next.st    = ST_ROM;
        r_next.bcnt  = 7'd0;
      end
    end

    // Reset pulse detection wins over everything else
    if (rise && (r_reg.low_cnt >= RSTL_STD_CYC || (r_reg.od && r_reg.low_cnt >= RSTL_OD))) begin
      if (r_reg.low_cnt >= RSTL_STD_CYC) begin
        r_next.od = 1'b0;
      end
      r_next.st       = ST_PRES;
      r_next.pcnt     = 16'd0;
      r_next.slot_act = 1'b0;
      r_next.io_oe    = 1'b0;
      r_next.fvalid   = 1'b0;
      r_next.bcnt     = 7'd0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r_reg      <= '0;
      r_reg.sync <= 3'b111;
      r_reg.line <= 1'b1;
      r_reg.st   <= ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign io_out         = 1'b0;
  assign io_oe          = r_reg.io_oe;
  assign overdrive_flag = r_reg.od;
  assign resume_flag    = r_reg.rc;
  assign id_valid       = r_reg.id_ok;
  assign func_code      = r_reg.fcode;
  assign func_valid     = r_reg.fvalid;

endmodule

// File: sim/swa_slave_assertions.sv
// Port checker for the single-wire slave
`timescale 1ns/1ps

module swa_slave_chk #(
  parameter logic [15:0] RSTL_STD_CYC = 16'd48000,
  parameter logic [15:0] PDL_STD_CYC  = 16'd6000
) (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       io_in,
  input wire logic       io_out,
  input wire logic       io_oe,
  input wire logic       overdrive_flag,
  input wire logic       resume_flag,
  input wire logic       id_valid,
  input wire logic [7:0] func_code,
  input wire logic       func_valid
);
  // -----------
  // Helper counters
  // -----------
  logic [15:0] low_reg;
  logic [15:0] pres_reg;
  logic [15:0] fall_reg;
  logic        in_d_reg;

  // Saturate so a long idle never wraps into a window
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      low_reg  <= '0;
      pres_reg <= '1;
      fall_reg <= '1;
      in_d_reg <= 1'b1;
    end else begin
      low_reg  <= io_in ? '0 : low_reg + 16'(low_reg != '1);
      pres_reg <= (io_in && low_reg >= 16'd4804) ? '0 : pres_reg + 16'(pres_reg != '1);
      fall_reg <= (in_d_reg && !io_in) ? '0 : fall_reg + 16'(fall_reg != '1);
      in_d_reg <= io_in;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence long_low_end;
    $rose(io_in) && low_reg >= 16'd4804;
  endsequence

  sequence std_rst_end;
    $rose(io_in) && low_reg >= RSTL_STD_CYC + 16'd4;
  endsequence

  id_ready_a:
    assert property ($rose(resetn) |-> ##[1:100] id_valid)
    else $error("id check not ready in time");
  od_clear_a:
    assert property (std_rst_end |-> ##[1:8] !overdrive_flag)
    else $error("long reset kept overdrive");
  od_keep_a:
    assert property (overdrive_flag && $rose(io_in) && low_reg < RSTL_STD_CYC - 16'd4
      |-> ##8 overdrive_flag)
    else $error("overdrive lost on short low");
  od_set_a:
    assert property ($rose(overdrive_flag) |-> fall_reg inside {[16'd2990:16'd3200]})
    else $error("overdrive set off the last command slot");
  pres_low_a:
    assert property ((overdrive_flag ? pres_reg inside {[16'd210:16'd990]}
      : pres_reg inside {[16'd1510:16'd1490 + PDL_STD_CYC]}) |-> io_oe)
    else $error("line released inside presence window");
  slot_answer_a:
    assert property ($rose(io_oe) |-> fall_reg <= 16'd8 || pres_reg inside {[16'd190:16'd1520]})
    else $error("device pulled outside a slot");
  od_hold_a:
    assert property (overdrive_flag && $rose(io_oe) && fall_reg <= 16'd8
      |-> ##185 io_oe ##[1:30] !io_oe)
    else $error("overdrive read hold wrong");
  func_code_a:
    assert property ($rose(func_valid)
      |-> func_code inside {8'h11, 8'h22, 8'h33, 8'h44, 8'h66, 8'h77})
    else $error("unknown function accepted");
  func_clear_a:
    assert property (long_low_end |-> ##[1:8] !func_valid)
    else $error("function kept across reset pulse");
  resume_keep_a:
    assert property (long_low_end |-> $stable(resume_flag) [*8])
    else $error("resume flag changed by reset pulse");
endmodule

bind swa_slave swa_slave_chk #(
  .RSTL_STD_CYC(RSTL_STD_CYC),
  .PDL_STD_CYC (PDL_STD_CYC)
) chk_u (
  .clock(clock), .resetn(resetn), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
  .overdrive_flag(overdrive_flag), .resume_flag(resume_flag), .id_valid(id_valid),
  .func_code(func_code), .func_valid(func_valid)
);

// File: sim/swa_master_model.sv
// Bus master model on the shared open-drain line
`timescale 1ns/1ps

module swa_master #(
  parameter int PDL_STD = 6000
) (
  input  wire logic clock,
  input  wire logic dev_oe,
  output logic      line
);
  // -----------
  // Wire and slot tasks
  // -----------
  logic drv;
  logic od;
  int   ts;
  int   th;

  // Pullup wins unless a party pulls low
  assign line = !(drv | dev_oe);
  assign ts = od ? 300 : 3000;
  assign th = od ? 200 : 1500;

  initial begin
    drv = 1'b0;
    od = 1'b0;
  end

  task automatic rst_pulse(input int len, output logic [1:0] pres);
    int pdl;
    pdl = od ? 800 : PDL_STD;
    drv = 1'b1;
    repeat (len) @(negedge clock);
    drv = 1'b0;
    repeat (th + 10) @(negedge clock);
    pres[0] = line;
    repeat (pdl - 20) @(negedge clock);
    pres[1] = line;
    repeat (100) @(negedge clock);
  endtask

  task automatic wr_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      drv = 1'b1;
      repeat (v[i] ? 10 : ts + 10) @(negedge clock);
      drv = 1'b0;
      repeat (v[i] ? ts + 10 : 10) @(negedge clock);
    end
  endtask

  task automatic rd_bits(input int n, output logic [63:0] v);
    v = '0;
    for (int i = 0; i < n; i++) begin
      drv = 1'b1;
      repeat (5) @(negedge clock);
      drv = 1'b0;
      repeat (50) @(negedge clock);
      v[i] = line;
      repeat (th - 35) @(negedge clock);
    end
  endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the single-wire slave
`timescale 1ns/1ps
`include "swa_defs.svh"

module tb_top;
  // -----------
  // Bench
  // -----------
  localparam logic [55:0] ID_BODY = {`SWA_SERIAL_NUM, `SWA_FAMILY_CODE};
  localparam logic [15:0] SIM_RSTL = 16'd6000;
  localparam int          SIM_PDL  = 600;
  logic        clock;
  logic        resetn;
  logic        line;
  logic        io_out;
  logic        io_oe;
  logic        od_f;
  logic        rs_f;
  logic        idv;
  logic        fv;
  logic [7:0]  fc;
  logic [1:0]  pres;
  logic [63:0] rv;
  logic [31:0] d1;
  logic [15:0] addr;
  int          err_count;
  int          compares;
  int          cyc;
  int          seed;

  // Short reset counts keep the run near 128 thousand cycles
  swa_slave #(.RSTL_STD_CYC(SIM_RSTL), .PDL_STD_CYC(16'(SIM_PDL))) dut_u (
    .clock(clock), .resetn(resetn), .io_in(line), .io_out(io_out), .io_oe(io_oe),
    .overdrive_flag(od_f), .resume_flag(rs_f), .id_valid(idv),
    .func_code(fc), .func_valid(fv));
  swa_master #(.PDL_STD(SIM_PDL)) mst_u (.clock(clock), .dev_oe(io_oe), .line(line));

  initial clock = 1'b0;
  always #5 clock = !clock;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] crc8(input logic [63:0] v, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) begin
      c = {1'b0, c[7:1]} ^ ((c[0] ^ v[i]) ? 8'h8c : 8'h00);
    end
    return c;
  endfunction

  task automatic prog_blk(input logic [31:0] d, input logic [7:0] st);
    mst_u.wr_byte(8'h22);
    check({fv, fc}, {1'b1, 8'h22});
    mst_u.wr_byte(addr[7:0]);
    mst_u.wr_byte(addr[15:8]);
    for (int i = 0; i < 4; i++)
      mst_u.wr_byte(d[8*i +: 8]);
    mst_u.rd_bits(8, rv);
    check(rv[7:0], st);
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 140000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    seed = 95583;
    err_count = 0;
    compares = 0;
    cyc = 0;
    resetn = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    repeat (100) @(negedge clock);
    check(idv, 1'b1);
    mst_u.rst_pulse(6200, pres);
    check(pres, 2'b00);
    check(io_out, 1'b0);
    mst_u.wr_byte(8'h3c);
    check(od_f, 1'b1);
    mst_u.od = 1'b1;
    d1 = $random(seed);
    addr = 16'($unsigned($random(seed)) % 24);
    prog_blk(d1, 8'haa);
    // Identity read, then a second program of the same block
    mst_u.rst_pulse(4900, pres);
    check(pres, 2'b00);
    check(od_f, 1'b1);
    check(fv, 1'b0);
    mst_u.wr_byte(8'h33);
    mst_u.rd_bits(64, rv);
    check(rv, {crc8(ID_BODY, 56), ID_BODY});
    check(crc8(rv, 64), 8'h00);
    prog_blk(~d1, 8'h55);
    check(rs_f, 1'b0);
    // Locked block unchanged, following byte still blank
    mst_u.rst_pulse(4900, pres);
    mst_u.wr_byte(8'hcc);
    mst_u.wr_byte(8'h11);
    mst_u.wr_byte({addr[7:2], 2'b00});
    mst_u.wr_byte(addr[15:8]);
    mst_u.rd_bits(40, rv);
    check(rv[31:0], d1);
    check(rv[39:32], 8'h00);
    mst_u.od = 1'b0;
    mst_u.rst_pulse(6200, pres);
    check(pres, 2'b00);
    check(od_f, 1'b0);
    final_report();
  end
endmodule
